// ==== psel_partition_ctrl.sv ====
// Partition control settings store with selection, enable control and request lookup
`timescale 1ns/1ns
`include "psel_regs.svh"

//
// Behaviour
// R1: Each request's id selects its control settings
// R2: Secure settings only through secure page
// R3: Instance field picks addressed resource instance
// R4: Selected id, space, instance address settings
// R5: Select at 0x0100, bandwidth max at 0x0208
// R6: One enable bit per id, component-wide
// R7: Disabled partition allocates nothing, second lowest priority
// R8: Disable without hint keeps settings intact
// R9: Disable with hint may keep settings
// R10: Enable/disable acts in the page's space
// R11: Disabled partition settings stay accessible
// R12: Enable/disable covers every resource instance
// R13: Flag vector maps 32 ids from masked base
// R14: Flag vector clear keeps settings
// R15: Software re-enables via enable register write
// R16: Enable looked up with request's id
// R17: Fractional controls read zero when disabled
// R18: Portion controls allocate nothing when disabled
// R19: Disabled lines get second lowest priority
// R20: Reset enables partition 0 only
// R21: Narrowing disable maps to empty internal id
// R22: Narrowing component omits no-future-use bit
// R23: Single enable bit shared by three views
module psel_partition_ctrl import psel_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Feature page register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_secure,
  input wire logic [11:0] reg_offset,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Partition-tagged requests
  input wire logic req_valid,
  input wire logic req_secure,
  input wire psel_partition_id_t req_partition_id,
  input wire psel_ris_t req_ris,
  // Settings applied to each request
  output logic grant_valid,
  output psel_partition_id_t grant_partition_id,
  output logic grant_enabled,
  output logic grant_alloc,
  output logic [15:0] grant_bw_max,
  output logic [2:0] grant_priority
);

  // Select register per space, settings store, read path
  psel_partition_id_t sel_partition_id [2];
  psel_partition_id_t next_sel_partition_id [2];
  psel_ris_t sel_ris [2];
  psel_ris_t next_sel_ris [2];
  logic [15:0] bw_store [256];
  logic [15:0] next_bw_store [256];
  logic [31:0] next_rdata;
  logic next_rvalid;

  // Decoded access
  psel_space_t acc_space;
  psel_partition_id_t acc_partition_id;
  psel_ris_t acc_ris;
  psel_cfg_idx_t cfg_idx;
  logic cfg_ok;
  logic wr_select;
  logic wr_bw;
  logic wr_enable;
  logic wr_disable;
  logic wr_flags;
  logic [31:0] flags_rdata;

  // Request lookup
  psel_space_t look_space;
  psel_cfg_idx_t req_idx;
  logic req_ok;
  logic look_enabled;
  logic [15:0] req_setting;

  // Partition id inside the implemented range
  function automatic logic id_ok(input psel_partition_id_t id);
    id_ok = (id < `PSEL_NUM_PARTITION_ID);
  endfunction

  // Resource instance inside the implemented range
  function automatic logic ris_ok(input psel_ris_t resource_instance_field);
    ris_ok = `PSEL_INSTANCE_SELECT_PRESENT ? (resource_instance_field < `PSEL_NUM_RIS) : (resource_instance_field == 8'h00);
  endfunction

  // Store index built from space, instance and partition
  function automatic psel_cfg_idx_t cfg_index(input logic sp, input psel_ris_t resource_instance_field, input psel_partition_id_t id);
    cfg_index = {sp, resource_instance_field[0], id[5:0]};
  endfunction

  // Address space of the access picks the partition space and its select register
  assign acc_space = reg_secure ? PSEL_SP_SECURE : PSEL_SP_NONSECURE; // R2
  assign acc_partition_id = sel_partition_id[acc_space]; // R4
  assign acc_ris = sel_ris[acc_space]; // R3
  assign cfg_idx = cfg_index(acc_space, acc_ris, acc_partition_id); // R4
  assign cfg_ok = id_ok(acc_partition_id) && ris_ok(acc_ris);

  // Register write strobes
  assign wr_select = reg_wr && (reg_offset == `PSEL_OFF_SELECT); // R5
  assign wr_bw = reg_wr && (reg_offset == `PSEL_OFF_BW_MAX); // R5
  assign wr_enable = reg_wr && (reg_offset == `PSEL_OFF_ENABLE); // R15
  // No-future-use hint in the top bit is ignored: settings are always kept, and no id narrowing is built
  assign wr_disable = reg_wr && (reg_offset == `PSEL_OFF_DISABLE); // R22
  assign wr_flags = reg_wr && (reg_offset == `PSEL_OFF_EN_FLAGS);

  // Selection register next values
  always_comb begin
    next_sel_partition_id = sel_partition_id;
    next_sel_ris = sel_ris;
    if (wr_select) begin
      next_sel_partition_id[acc_space] = reg_wdata[`PSEL_PARTITION_ID_MSB:`PSEL_PARTITION_ID_LSB]; // R4
      next_sel_ris[acc_space] = `PSEL_INSTANCE_SELECT_PRESENT ? reg_wdata[`PSEL_RIS_MSB:`PSEL_RIS_LSB] : `PSEL_RIS_RESET; // R3
    end
  end

  // Selection registers, one per space
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_partition_id[0] <= `PSEL_SEL_RESET;
      sel_partition_id[1] <= `PSEL_SEL_RESET;
      sel_ris[0] <= `PSEL_RIS_RESET;
      sel_ris[1] <= `PSEL_RIS_RESET;
    end else begin
      sel_partition_id <= next_sel_partition_id;
      sel_ris <= next_sel_ris;
    end
  end

  // Settings writes ignore the enable state, so a disabled id stays programmable
  always_comb begin
    next_bw_store = bw_store;
    if (wr_bw && cfg_ok) begin
      next_bw_store[cfg_idx] = reg_wdata[`PSEL_BW_MSB:0]; // R11
    end
  end

  // Disable never writes here; settings survive with or without the hint
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < 256; k++) begin
        bw_store[k] <= `PSEL_BW_RESET;
      end
    end else begin
      bw_store <= next_bw_store; // R8 R9 R14
    end
  end

  // Enable bits, shared by every instance of a partition
  psel_enable_store u_enable_store (
    .core_clk(core_clk),
    .reset(reset),
    .wr_space(acc_space),
    .en_cmd(wr_enable), // R15
    .dis_cmd(wr_disable),
    .cmd_partition_id(reg_wdata[`PSEL_PARTITION_ID_MSB:`PSEL_PARTITION_ID_LSB]),
    .flags_wr(wr_flags),
    .flags_base(acc_partition_id & `PSEL_FLAG_BASE_MASK), // R13
    .flags_wdata(reg_wdata),
    .flags_rdata(flags_rdata),
    .look_space(look_space),
    .look_partition_id(req_partition_id),
    .look_enabled(look_enabled)
  );

  // Read data, returned the cycle after the read strobe
  always_comb begin
    next_rvalid = reg_rd;
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_offset)
        `PSEL_OFF_SELECT: next_rdata = {8'h00, acc_ris, acc_partition_id};
        `PSEL_OFF_BW_MAX: next_rdata = cfg_ok ? {16'h0000, bw_store[cfg_idx]} : 32'h0000_0000; // R11
        `PSEL_OFF_EN_FLAGS: next_rdata = flags_rdata; // R13
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // Request id picks its settings; enable bit ignores the instance
  assign look_space = req_secure ? PSEL_SP_SECURE : PSEL_SP_NONSECURE;
  assign req_ok = id_ok(req_partition_id) && ris_ok(req_ris);
  assign req_idx = cfg_index(look_space, req_ris, req_partition_id); // R1
  assign req_setting = req_ok ? bw_store[req_idx] : 16'h0000; // R1

  // Outcome stage; enabled state is component-wide across all controls
  // Request ids are used as internal ids, so a disabled id only empties its own outcome
  psel_req_apply u_req_apply (
    .core_clk(core_clk),
    .reset(reset),
    .req_valid(req_valid),
    .req_partition_id(req_partition_id),
    .enabled(look_enabled && req_ok), // R6 R12 R21
    .bw_setting(req_setting),
    .grant_valid(grant_valid),
    .grant_partition_id(grant_partition_id),
    .grant_enabled(grant_enabled),
    .grant_alloc(grant_alloc),
    .grant_bw_max(grant_bw_max),
    .grant_priority(grant_priority)
  );

endmodule // psel_partition_ctrl

// ==== psel_regs.svh ====
// Register offsets, field positions, reset values and sizes of the partition select block
`ifndef PSEL_REGS_SVH
`define PSEL_REGS_SVH

// Register offsets within each feature page
`define PSEL_OFF_SELECT 12'h100
`define PSEL_OFF_BW_MAX 12'h208
`define PSEL_OFF_DISABLE 12'h300
`define PSEL_OFF_ENABLE 12'h308
`define PSEL_OFF_EN_FLAGS 12'h320

// Field positions
`define PSEL_PARTITION_ID_MSB 15
`define PSEL_PARTITION_ID_LSB 0
`define PSEL_RIS_MSB 23
`define PSEL_RIS_LSB 16
`define PSEL_NFU_BIT 31
`define PSEL_BW_MSB 15

// Flag vector block base mask
`define PSEL_FLAG_BASE_MASK 16'hffe0

// Sizes of the settings store
`define PSEL_NUM_PARTITION_ID 16'h0040
`define PSEL_NUM_RIS 8'h02
`define PSEL_INSTANCE_SELECT_PRESENT 1'b1

// Reset values
`define PSEL_EN_RESET 64'h0000_0000_0000_0001
`define PSEL_BW_RESET 16'hffff
`define PSEL_SEL_RESET 16'h0000
`define PSEL_RIS_RESET 8'h00

// Allocation priorities applied to a request
`define PSEL_PRIO_DISABLED 3'h1
`define PSEL_PRIO_ENABLED 3'h3

`endif

// ==== psel_pkg.sv ====
// Types shared by the partition select block
package psel_pkg;

  // Partition id as carried in registers and on requests
  typedef logic [15:0] psel_partition_id_t;

  // Index into one space's 64 partitions
  typedef logic [5:0] psel_pidx_t;

  // Resource instance number as held in the select register
  typedef logic [7:0] psel_ris_t;

  // Index into the settings store: space, instance, partition
  typedef logic [7:0] psel_cfg_idx_t;

  // Partition space chosen by the address space of an access
  typedef enum logic {PSEL_SP_NONSECURE, PSEL_SP_SECURE} psel_space_t;

endpackage

// ==== psel_enable_store.sv ====
// Per-space partition enable bits with command, flag vector and lookup views
`timescale 1ns/1ns
module psel_enable_store import psel_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register-side commands
  input wire psel_space_t wr_space,
  input wire logic en_cmd,
  input wire logic dis_cmd,
  input wire psel_partition_id_t cmd_partition_id,
  input wire logic flags_wr,
  input wire psel_partition_id_t flags_base,
  input wire logic [31:0] flags_wdata,
  output logic [31:0] flags_rdata,
  // Request lookup
  input wire psel_space_t look_space,
  input wire psel_partition_id_t look_partition_id,
  output logic look_enabled
);

  logic [63:0] en_bits [2];
  logic [63:0] next_en_bits [2];
  logic [15:0] fidx;
  int i;

  // Partition id inside the implemented range
  function automatic logic in_range(input psel_partition_id_t id);
    in_range = (id < `PSEL_NUM_PARTITION_ID);
  endfunction

  // One bit per id per space serves all three views
  always_comb begin
    next_en_bits = en_bits; // R23
    fidx = 16'h0000;
    flags_rdata = 32'h0000_0000;
    if (en_cmd && in_range(cmd_partition_id)) begin
      next_en_bits[wr_space][cmd_partition_id[5:0]] = 1'b1; // R10
    end
    if (dis_cmd && in_range(cmd_partition_id)) begin
      next_en_bits[wr_space][cmd_partition_id[5:0]] = 1'b0; // R10
    end
    for (i = 0; i < 32; i++) begin
      fidx = flags_base + 16'(i); // R13
      if (in_range(fidx)) begin
        flags_rdata[i] = en_bits[wr_space][fidx[5:0]];
        if (flags_wr) begin
          // Clearing here never touches settings, they live elsewhere
          next_en_bits[wr_space][fidx[5:0]] = flags_wdata[i]; // R14
        end
      end
    end
  end

  // Only partition 0 comes up enabled in each space
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_bits[0] <= `PSEL_EN_RESET; // R20
      en_bits[1] <= `PSEL_EN_RESET; // R20
    end else begin
      en_bits <= next_en_bits;
    end
  end

  // Lookup uses the id exactly as carried on the request
  assign look_enabled = in_range(look_partition_id) && en_bits[look_space][look_partition_id[5:0]]; // R16

endmodule // psel_enable_store

// ==== psel_req_apply.sv ====
// Applies a partition's enabled state and settings to one request
`timescale 1ns/1ns
module psel_req_apply import psel_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Looked-up request
  input wire logic req_valid,
  input wire psel_partition_id_t req_partition_id,
  input wire logic enabled,
  input wire logic [15:0] bw_setting,
  // Registered outcome
  output logic grant_valid,
  output psel_partition_id_t grant_partition_id,
  output logic grant_enabled,
  output logic grant_alloc,
  output logic [15:0] grant_bw_max,
  output logic [2:0] grant_priority
);

  logic next_valid;
  psel_partition_id_t next_partition_id;
  logic next_enabled;
  logic next_alloc;
  logic [15:0] next_bw_max;
  logic [2:0] next_priority;

  // A disabled partition allocates nothing and sits at the low priority
  always_comb begin
    next_valid = req_valid;
    next_partition_id = req_partition_id;
    next_enabled = enabled;
    next_alloc = enabled; // R18 R7
    next_bw_max = enabled ? bw_setting : 16'h0000; // R17 R7
    next_priority = enabled ? `PSEL_PRIO_ENABLED : `PSEL_PRIO_DISABLED; // R19
  end

  // Outcome registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      grant_valid <= 1'b0;
      grant_partition_id <= 16'h0000;
      grant_enabled <= 1'b0;
      grant_alloc <= 1'b0;
      grant_bw_max <= 16'h0000;
      grant_priority <= 3'h0;
    end else begin
      grant_valid <= next_valid;
      grant_partition_id <= next_partition_id;
      grant_enabled <= next_enabled;
      grant_alloc <= next_alloc;
      grant_bw_max <= next_bw_max;
      grant_priority <= next_priority;
    end
  end

endmodule // psel_req_apply

// ==== psel_partition_ctrl_chk.sv ====
// Port checks of the partition select block
`timescale 1ns/1ns
module psel_partition_ctrl_chk import psel_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Watched ports
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic req_valid,
  input wire psel_partition_id_t req_partition_id,
  input wire logic grant_valid,
  input wire psel_partition_id_t grant_partition_id,
  input wire logic grant_enabled,
  input wire logic grant_alloc,
  input wire logic [15:0] grant_bw_max,
  input wire logic [2:0] grant_priority
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Read answers one cycle after the strobe, never without one
  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_no_rd; !reg_rd |=> !reg_rvalid; endproperty
  a_no_rd: assert property (p_no_rd) else $error("read answer without read");
  // Each request gets its own outcome, looked up with its own id
  property p_gv; req_valid |=> grant_valid; endproperty
  a_gv: assert property (p_gv) else $error("request lost");
  property p_gidle; !req_valid |=> !grant_valid; endproperty
  a_gidle: assert property (p_gidle) else $error("outcome without request");
  property p_gpid; req_valid |=> grant_partition_id == $past(req_partition_id); endproperty
  a_gpid: assert property (p_gpid) else $error("outcome id differs from request");
  property p_range; req_valid && req_partition_id >= 16'h0040 |=> !grant_enabled; endproperty
  a_range: assert property (p_range) else $error("unknown id enabled");
  // Disabled outcome: nothing allocated, zero fraction, priority just above empty
  property p_alloc; grant_valid |-> grant_alloc == grant_enabled; endproperty
  a_alloc: assert property (p_alloc) else $error("allocation disagrees with enable");
  property p_dis_bw; grant_valid && !grant_enabled |-> grant_bw_max == 16'h0000; endproperty
  a_dis_bw: assert property (p_dis_bw) else $error("disabled bandwidth not zero");
  property p_dis_pr; grant_valid && !grant_enabled |-> grant_priority == 3'h1; endproperty
  a_dis_pr: assert property (p_dis_pr) else $error("disabled priority wrong");
  property p_en_pr; grant_valid && grant_enabled |-> grant_priority == 3'h3; endproperty
  a_en_pr: assert property (p_en_pr) else $error("enabled priority wrong");
endmodule // psel_partition_ctrl_chk

bind psel_partition_ctrl psel_partition_ctrl_chk u_chk (.core_clk, .reset, .reg_rd, .reg_rvalid, .req_valid,
  .req_partition_id, .grant_valid, .grant_partition_id, .grant_enabled, .grant_alloc, .grant_bw_max, .grant_priority);

// ==== psel_req_model.sv ====
// Requester model issuing partition-tagged requests
`timescale 1ns/1ns
module psel_req_model import psel_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Request outputs
  output logic req_valid,
  output logic req_secure,
  output psel_partition_id_t req_partition_id,
  output psel_ris_t req_ris
);
  // Idle at time zero
  initial begin
    req_valid = 1'b0;
    req_secure = 1'b0;
    req_partition_id = 16'h0000;
    req_ris = 8'h00;
  end

  // One request per call; idle id and instance fields show the inverse so stale ids never look valid
  task automatic issue(input logic sec, input psel_partition_id_t pid, input psel_ris_t resource_instance_field);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_secure <= sec;
    req_partition_id <= pid;
    req_ris <= resource_instance_field;
    @(posedge core_clk);
    req_valid <= 1'b0;
    req_partition_id <= ~pid;
    req_ris <= ~resource_instance_field;
  endtask
endmodule // psel_req_model

// ==== test_psel_partition_ctrl.sv ====
// Self-checking testbench of the partition select block
`timescale 1ns/1ns
`include "psel_regs.svh"
module test_psel_partition_ctrl import psel_pkg::*;;
  logic core_clk, reset, reg_wr, reg_rd, reg_secure, reg_rvalid;
  logic [11:0] reg_offset;
  logic [31:0] reg_wdata, reg_rdata;
  logic req_valid, req_secure, grant_valid, grant_enabled, grant_alloc;
  psel_partition_id_t req_partition_id, grant_partition_id;
  psel_ris_t req_ris;
  logic [15:0] grant_bw_max;
  logic [2:0] grant_priority;
  int err_total = 0;
  int check_count = 0;
  localparam logic [11:0] o_sel = `PSEL_OFF_SELECT;
  localparam logic [11:0] o_bw = `PSEL_OFF_BW_MAX;
  localparam logic [11:0] o_dis = `PSEL_OFF_DISABLE;
  localparam logic [11:0] o_en = `PSEL_OFF_ENABLE;
  localparam logic [11:0] o_fl = `PSEL_OFF_EN_FLAGS;

  psel_partition_ctrl dut (.core_clk, .reset, .reg_wr, .reg_rd, .reg_secure, .reg_offset, .reg_wdata,
    .reg_rdata, .reg_rvalid, .req_valid, .req_secure, .req_partition_id, .req_ris, .grant_valid, .grant_partition_id,
    .grant_enabled, .grant_alloc, .grant_bw_max, .grant_priority);
  psel_req_model model (.core_clk, .req_valid, .req_secure, .req_partition_id, .req_ris);

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write: strobe held for exactly one taken edge
  task automatic wr(input logic sec, input logic [11:0] off, input logic [31:0] data);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_secure <= sec;
    reg_offset <= off;
    reg_wdata <= data;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Register read: answer stands for one cycle after the taking edge
  task automatic rd(input string what, input logic sec, input logic [11:0] off, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_secure <= sec;
    reg_offset <= off;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp({what, " rvalid"}, 32'h1, {31'h0, reg_rvalid});
    cmp(what, exp, reg_rdata);
  endtask

  // Request through the model, outcome judged one cycle later
  task automatic req(input string what, input logic sec, input psel_partition_id_t pid, input psel_ris_t resource_instance_field,
                     input logic en, input logic [15:0] bw);
    model.issue(sec, pid, resource_instance_field);
    #1;
    cmp({what, " valid"}, 32'h1, {31'h0, grant_valid});
    cmp({what, " id"}, {16'h0, pid}, {16'h0, grant_partition_id});
    cmp({what, " en"}, {31'h0, en}, {31'h0, grant_enabled});
    cmp({what, " alloc"}, {31'h0, en}, {31'h0, grant_alloc});
    cmp({what, " bw"}, {16'h0, en ? bw : 16'h0}, {16'h0, grant_bw_max});
    cmp({what, " prio"}, {29'h0, en ? `PSEL_PRIO_ENABLED : `PSEL_PRIO_DISABLED}, {29'h0, grant_priority});
  endtask

  task automatic t_reset();
    rd("sel", 1'b0, o_sel, 32'h0);
    rd("flags", 1'b0, o_fl, 32'h1);
    rd("bw", 1'b0, o_bw, 32'hffff);
    req("id0", 1'b0, 16'h0000, 8'h00, 1'b1, 16'hffff);
    req("id1", 1'b1, 16'h0001, 8'h00, 1'b0, 16'h0);
  endtask

  task automatic t_space();
    wr(1'b1, o_sel, 32'h0001_000f);
    wr(1'b1, o_bw, 32'h0000_1234);
    rd("bw s", 1'b1, o_bw, 32'h1234);
    wr(1'b0, o_sel, 32'h0001_000f);
    rd("bw ns", 1'b0, o_bw, 32'hffff);
    wr(1'b1, o_sel, 32'h0000_000f);
    rd("sel s", 1'b1, o_sel, 32'h0000_000f);
    rd("bw ris0", 1'b1, o_bw, 32'hffff);
    rd("unmapped", 1'b1, 12'h004, 32'h0);
    rd("en wo", 1'b1, o_en, 32'h0);
  endtask

  task automatic t_endis();
    wr(1'b1, o_en, 32'h0000_000f);
    req("ris1", 1'b1, 16'h000f, 8'h01, 1'b1, 16'h1234);
    req("ris0", 1'b1, 16'h000f, 8'h00, 1'b1, 16'hffff);
    req("ns15", 1'b0, 16'h000f, 8'h01, 1'b0, 16'h0);
    wr(1'b1, o_dis, 32'h0000_000f);
    req("dis", 1'b1, 16'h000f, 8'h01, 1'b0, 16'h0);
    wr(1'b1, o_sel, 32'h0001_000f);
    rd("bw dis", 1'b1, o_bw, 32'h1234);
    wr(1'b1, o_bw, 32'h0000_0777);
    wr(1'b1, o_en, 32'h0000_000f);
    req("reen", 1'b1, 16'h000f, 8'h01, 1'b1, 16'h0777);
    wr(1'b1, o_dis, 32'h8000_000f);
    wr(1'b1, o_en, 32'h0000_000f);
    req("nfu", 1'b1, 16'h000f, 8'h01, 1'b1, 16'h0777);
  endtask

  task automatic t_flags();
    wr(1'b1, o_sel, 32'h0000_0028);
    wr(1'b1, o_fl, 32'hffff_feff);
    rd("flags hi", 1'b1, o_fl, 32'hffff_feff);
    req("id63", 1'b1, 16'h003f, 8'h00, 1'b1, 16'hffff);
    req("id40", 1'b1, 16'h0028, 8'h00, 1'b0, 16'h0);
    wr(1'b1, o_sel, 32'h0000_0008);
    rd("flags lo", 1'b1, o_fl, 32'h0000_8001);
    wr(1'b1, o_fl, 32'h0000_0001);
    req("fl off", 1'b1, 16'h000f, 8'h01, 1'b0, 16'h0);
    wr(1'b1, o_en, 32'h0000_000f);
    req("fl keep", 1'b1, 16'h000f, 8'h01, 1'b1, 16'h0777);
    wr(1'b1, o_sel, 32'h0000_0040);
    wr(1'b1, o_fl, 32'hffff_ffff);
    rd("flags oor", 1'b1, o_fl, 32'h0);
    rd("bw oor", 1'b1, o_bw, 32'h0);
    req("id64", 1'b1, 16'h0040, 8'h00, 1'b0, 16'h0);
    wr(1'b1, o_sel, 32'h0002_000f);
    rd("bw ris2", 1'b1, o_bw, 32'h0);
    req("ris2", 1'b1, 16'h000f, 8'h02, 1'b0, 16'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_secure = 1'b0;
    reg_offset = 12'h000;
    reg_wdata = 32'h0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_space();
    t_endis();
    t_flags();
    complete_run();
  end

  // Watchdog: the sequence needs well under 400 cycles
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
endmodule // test_psel_partition_ctrl
